// ### ppef_defines.svh
`ifndef PPEF_DEFINES_SVH
`define PPEF_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define PPEF_OFF_SENSE 12'h404
`define PPEF_OFF_BOTH 12'h408
`define PPEF_OFF_POL 12'h40c
`define PPEF_OFF_ENA 12'h410
`define PPEF_OFF_RAW 12'h414
`define PPEF_OFF_MSK 12'h418
`define PPEF_OFF_CLR 12'h41c
`define PPEF_OFF_FUNC 12'h420

// ==========================================================
// Reset values
`define PPEF_RST_ZERO 8'h00
`define PPEF_RST_FUNC_B 8'h80
`define PPEF_RST_FUNC_C 8'h0f

// ==========================================================
// Field positions and response codes
`define PPEF_TRIG_BIT 4
`define PPEF_RESP_OKAY 2'b00
`define PPEF_RESP_SLVERR 2'b10

`endif

// ### ppef_pkg.sv
package ppef_pkg;

   // ==========================================================
   // Per-pin configuration carried as one group
   typedef struct packed {
      logic [7:0] sense;
      logic [7:0] both;
      logic [7:0] pol;
      logic [7:0] ena;
   } ppef_cfg_t;

   typedef enum logic [1:0] {
      PPEF_PORT_PLAIN,
      PPEF_PORT_B,
      PPEF_PORT_C
   } ppef_port_t;

endpackage

// ### ppef_port_events.sv
`include "ppef_defines.svh"

module ppef_port_events #(
   parameter ppef_pkg::ppef_port_t PORT_KIND = ppef_pkg::PPEF_PORT_PLAIN,
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Pins
   input wire logic [WIDTH-1:0] pin_in,
   // Outputs
   output logic [WIDTH-1:0] function_select,
   output logic [WIDTH-1:0] pin_interrupt,
   output logic combined_port_interrupt,
   output logic converter_trigger
);

   // ==========================================================
   // Reset value of the function field
   localparam logic [WIDTH-1:0] FUNC_RST =
      (PORT_KIND == ppef_pkg::PPEF_PORT_B) ? WIDTH'(`PPEF_RST_FUNC_B) :
      (PORT_KIND == ppef_pkg::PPEF_PORT_C) ? WIDTH'(`PPEF_RST_FUNC_C) :
      WIDTH'(`PPEF_RST_ZERO);

   // ==========================================================
   // State
   ppef_pkg::ppef_cfg_t cfg;
   logic [WIDTH-1:0] func_sel;
   logic [WIDTH-1:0] edge_latch;
   logic [WIDTH-1:0] pin_meta;
   logic [WIDTH-1:0] pin_sync;
   logic [WIDTH-1:0] pin_prev;
   logic [WIDTH-1:0] raw_flags;
   logic aw_held;
   logic w_held;
   logic [11:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   // ==========================================================
   // Event detection
   wire [WIDTH-1:0] rise = pin_sync & ~pin_prev;
   wire [WIDTH-1:0] fall = ~pin_sync & pin_prev;
   wire [WIDTH-1:0] one_edge = (cfg.pol[WIDTH-1:0] & rise) |
                               (~cfg.pol[WIDTH-1:0] & fall);
   wire [WIDTH-1:0] edge_hit = ~cfg.sense[WIDTH-1:0] &
      ((cfg.both[WIDTH-1:0] & (rise | fall)) |
       (~cfg.both[WIDTH-1:0] & one_edge));
   // Level pins track the pin, so a clear cannot hold them low
   wire [WIDTH-1:0] level_hit = cfg.sense[WIDTH-1:0] &
      ~(pin_sync ^ cfg.pol[WIDTH-1:0]);
   wire [WIDTH-1:0] masked_flags = raw_flags & cfg.ena[WIDTH-1:0];

   // ==========================================================
   // Write path decode
   // Commit only once both halves are held, in the edge that raises bvalid
   wire do_write = aw_held & w_held & ~bvalid & clk_en;
   wire [11:0] wr_addr = aw_addr_q;
   wire [31:0] wr_data = w_data_q;
   wire [3:0] wr_strb = w_strb_q;
   // Only the low byte lane carries fields; upper bits are dropped
   wire wr_lane0 = wr_strb[0];
   wire [WIDTH-1:0] wr_byte = wr_data[WIDTH-1:0];
   wire wr_sense = do_write & wr_lane0 & (wr_addr == `PPEF_OFF_SENSE);
   wire wr_both = do_write & wr_lane0 & (wr_addr == `PPEF_OFF_BOTH);
   wire wr_pol = do_write & wr_lane0 & (wr_addr == `PPEF_OFF_POL);
   wire wr_ena = do_write & wr_lane0 & (wr_addr == `PPEF_OFF_ENA);
   wire wr_clr = do_write & wr_lane0 & (wr_addr == `PPEF_OFF_CLR);
   wire wr_func = do_write & wr_lane0 & (wr_addr == `PPEF_OFF_FUNC);
   wire wr_known = (wr_addr == `PPEF_OFF_SENSE) | (wr_addr == `PPEF_OFF_BOTH) |
                   (wr_addr == `PPEF_OFF_POL) | (wr_addr == `PPEF_OFF_ENA) |
                   (wr_addr == `PPEF_OFF_RAW) | (wr_addr == `PPEF_OFF_MSK) |
                   (wr_addr == `PPEF_OFF_CLR) | (wr_addr == `PPEF_OFF_FUNC);
   // A new event in the clearing cycle wins over the clear
   wire [WIDTH-1:0] clr_mask = wr_clr ? wr_byte : '0;
   wire [WIDTH-1:0] next_edge_latch = (edge_latch & ~clr_mask) | edge_hit;
   wire [WIDTH-1:0] next_raw = next_edge_latch | level_hit;

   // ==========================================================
   // Read path decode
   wire do_read = arvalid & ~rvalid & clk_en;
   wire [WIDTH-1:0] rd_byte =
      (araddr == `PPEF_OFF_SENSE) ? cfg.sense[WIDTH-1:0] :
      (araddr == `PPEF_OFF_BOTH) ? cfg.both[WIDTH-1:0] :
      (araddr == `PPEF_OFF_POL) ? cfg.pol[WIDTH-1:0] :
      (araddr == `PPEF_OFF_ENA) ? cfg.ena[WIDTH-1:0] :
      (araddr == `PPEF_OFF_RAW) ? raw_flags :
      (araddr == `PPEF_OFF_MSK) ? masked_flags :
      (araddr == `PPEF_OFF_FUNC) ? func_sel : '0; // clear register reads zero
   wire rd_known = (araddr == `PPEF_OFF_SENSE) | (araddr == `PPEF_OFF_BOTH) |
                   (araddr == `PPEF_OFF_POL) | (araddr == `PPEF_OFF_ENA) |
                   (araddr == `PPEF_OFF_RAW) | (araddr == `PPEF_OFF_MSK) |
                   (araddr == `PPEF_OFF_CLR) | (araddr == `PPEF_OFF_FUNC);

   // ==========================================================
   // Pin synchroniser
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_prev <= '0;
      end
      else if (clk_en)
      begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg <= '0;
         func_sel <= FUNC_RST;
      end
      else
      begin
         if (wr_sense) cfg.sense[WIDTH-1:0] <= wr_byte;
         if (wr_both) cfg.both[WIDTH-1:0] <= wr_byte;
         if (wr_pol) cfg.pol[WIDTH-1:0] <= wr_byte;
         if (wr_ena) cfg.ena[WIDTH-1:0] <= wr_byte;
         if (wr_func) func_sel <= wr_byte;
      end
   end

   // ==========================================================
   // Event flags and interrupt outputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         edge_latch <= '0;
         raw_flags <= '0;
         function_select <= FUNC_RST;
         pin_interrupt <= '0;
         combined_port_interrupt <= 1'b0;
         converter_trigger <= 1'b0;
      end
      else if (clk_en)
      begin
         edge_latch <= next_edge_latch;
         raw_flags <= next_raw;
         function_select <= func_sel;
         pin_interrupt <= masked_flags;
         combined_port_interrupt <= |masked_flags;
         // Pulse on each new port B bit 4 event that is enabled
         converter_trigger <= (PORT_KIND == ppef_pkg::PPEF_PORT_B) &&
            cfg.ena[`PPEF_TRIG_BIT] &&
            (edge_hit[`PPEF_TRIG_BIT] ||
             (level_hit[`PPEF_TRIG_BIT] && !raw_flags[`PPEF_TRIG_BIT]));
      end
   end

   // ==========================================================
   // AXI4-Lite write channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `PPEF_RESP_OKAY;
      end
      else if (clk_en)
      begin
         awready <= 1'b0;
         wready <= 1'b0;
         if (awvalid && !aw_held && !awready && !bvalid)
         begin
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
            awready <= 1'b1;
         end
         if (wvalid && !w_held && !wready && !bvalid)
         begin
            w_held <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            wready <= 1'b1;
         end
         if (aw_held && w_held && !bvalid)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_known ? `PPEF_RESP_OKAY : `PPEF_RESP_SLVERR;
         end
         else if (bvalid && bready)
         begin
            bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= `PPEF_RESP_OKAY;
      end
      else if (clk_en)
      begin
         arready <= 1'b0;
         if (do_read && !arready)
         begin
            arready <= 1'b1;
            rvalid <= 1'b1;
            rdata <= {{(32 - WIDTH){1'b0}}, rd_byte};
            rresp <= rd_known ? `PPEF_RESP_OKAY : `PPEF_RESP_SLVERR;
         end
         else if (rvalid && rready)
         begin
            rvalid <= 1'b0;
         end
      end
   end

endmodule // ppef_port_events

// ### ppef_port_events_asserts.sv
module ppef_port_events_asserts #(
   parameter ppef_pkg::ppef_port_t PORT_KIND = ppef_pkg::PPEF_PORT_PLAIN,
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus answers
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   // Event outputs
   input wire logic [WIDTH-1:0] function_select,
   input wire logic [WIDTH-1:0] pin_interrupt,
   input wire logic combined_port_interrupt,
   input wire logic converter_trigger
);
   localparam logic [WIDTH-1:0] FUNC_RST = (PORT_KIND == ppef_pkg::PPEF_PORT_B) ? 8'h80 :
      (PORT_KIND == ppef_pkg::PPEF_PORT_C) ? 8'h0f : 8'h00;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // Event outputs
   a_comb_or: assert property (combined_port_interrupt == |pin_interrupt)
      else $error("combined interrupt differs from OR of pins");
   a_reset_out: assert property ($rose(aresetn) |-> pin_interrupt == '0 &&
      !combined_port_interrupt && !converter_trigger)
      else $error("interrupt output set after reset");
   a_func_rst: assert property ($rose(aresetn) |-> function_select == FUNC_RST)
      else $error("function select reset value wrong");
   a_func_write: assert property (!$stable(function_select) |-> bvalid || $past(bvalid))
      else $error("function select moved without a write");
   a_trig_pulse: assert property (converter_trigger |=> !converter_trigger)
      else $error("converter trigger longer than one cycle");
   // ==========================================================
   // Register bus
   a_rsv_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("reserved read bits not zero");
   a_rd_answer: assert property (arready |-> rvalid)
      else $error("read data not with address accept");
   a_wr_answer: assert property (awready && wready |=> bvalid)
      else $error("write response missing");
   c_trig: cover property (converter_trigger);
   c_irq: cover property (combined_port_interrupt);
   c_func: cover property (!$stable(function_select));
endmodule // ppef_port_events_asserts

bind ppef_port_events ppef_port_events_asserts #(.PORT_KIND(PORT_KIND), .WIDTH(WIDTH)) u_chk (
   .aclk, .aresetn, .awready, .wready, .bvalid, .arready, .rvalid, .rdata,
   .function_select, .pin_interrupt, .combined_port_interrupt, .converter_trigger);

// ### ppef_pin_model.sv
module ppef_pin_model (
   // Clock
   input wire logic aclk,
   // Requested levels and lag choice
   input wire logic [7:0] want,
   input wire logic slow,
   // Pins
   output logic [7:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] lag = 8'h00;
   // Pins move off the clock edge, as a real async source would
   initial pins = 8'h00;
   always @(posedge aclk)
   begin
      lag <= want;
      pins <= #7 (slow ? lag : want);
   end
endmodule // ppef_pin_model

// ### ppef_port_events_tb.sv
`include "ppef_defines.svh"
module ppef_port_events_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, slow = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, v;
   logic [3:0] wstrb = 4'hf;
   logic [7:0] want = 8'h00;
   logic awready, wready, bvalid, arready, rvalid, combined_port_interrupt, converter_trigger;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] pin_in, function_select, pin_interrupt;
   logic [33:0] wq[$], rq[$];
   int bad_count = 0, cmp_count = 0, trig_n = 0, seed = 32'he5d5bb3b;
   ppef_port_events #(.PORT_KIND(ppef_pkg::PPEF_PORT_B)) DUT (.aclk, .aresetn, .clk_en,
      .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
      .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .pin_in,
      .function_select, .pin_interrupt, .combined_port_interrupt, .converter_trigger);
   ppef_pin_model PINS (.aclk, .want, .slow, .pins(pin_in));
   initial forever #12.5 aclk = ~aclk;
   // ==========================================================
   // Checking
   task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
      cmp_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic ports(input logic [16:0] e);
      @(negedge aclk);
      chk("ports", {17'h0, e}, {17'h0, combined_port_interrupt, pin_interrupt, function_select});
   endtask
   always @(posedge aclk)
   begin
      trig_n += converter_trigger;
      if (bvalid && bready)
         chk("bresp", wq.pop_front(), {bresp, 32'h0});
      if (rvalid && rready)
         chk("read", rq.pop_front(), {rresp, rdata});
   end
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==========================================================
   // Bus master
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ta, tw, tb;
      wq.push_back({r, 32'h0});
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ta = awready;
         tw = wready;
         tb = bvalid;
         @(posedge aclk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
      end
      while (!tb);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      logic ta, tr;
      rq.push_back(e);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ta = arready;
         tr = rvalid;
         @(posedge aclk);
         if (ta)
            arvalid <= 1'b0;
      end
      while (!tr);
      rready <= 1'b0;
   endtask
   task automatic setp(input logic [7:0] p);
      want <= p;
      repeat (8) @(posedge aclk);
   endtask
   // ==========================================================
   // Scenarios
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 12'h408; i <= 12'h41c; i += 4)
         rd(i[11:0], 34'h0);
      ports({1'b0, 8'h00, 8'h80});
      $display("reset test done");
      repeat (4)
      begin
         v = $random(seed);
         wr(`PPEF_OFF_POL, v, 2'b00);
         rd(`PPEF_OFF_POL, {26'h0, v[7:0]});
      end
      wr(`PPEF_OFF_RAW, 32'hff, 2'b00);
      rd(`PPEF_OFF_RAW, 34'h0);
      wr(12'h500, 32'h1, 2'b10);
      rd(12'h500, {2'b10, 32'h0});
      $display("register test done");
      wr(`PPEF_OFF_POL, 32'hff, 2'b00);
      wr(`PPEF_OFF_ENA, 32'h01, 2'b00);
      wr(`PPEF_OFF_CLR, 32'hff, 2'b00);
      setp(8'h03);
      rd(`PPEF_OFF_RAW, 34'h03);
      rd(`PPEF_OFF_MSK, 34'h01);
      ports({1'b1, 8'h01, 8'h80});
      wr(`PPEF_OFF_CLR, 32'h02, 2'b00);
      rd(`PPEF_OFF_RAW, 34'h01);
      wr(`PPEF_OFF_BOTH, 32'h04, 2'b00);
      setp(8'h0c);
      wr(`PPEF_OFF_CLR, 32'hff, 2'b00);
      ports({1'b0, 8'h00, 8'h80});
      setp(8'h00);
      rd(`PPEF_OFF_RAW, 34'h04);
      wr(`PPEF_OFF_POL, 32'h00, 2'b00);
      wr(`PPEF_OFF_CLR, 32'hff, 2'b00);
      setp(8'h08);
      setp(8'h00);
      rd(`PPEF_OFF_RAW, 34'h08);
      $display("edge test done");
      slow <= 1'b1;
      wr(`PPEF_OFF_SENSE, 32'h30, 2'b00);
      wr(`PPEF_OFF_CLR, 32'h30, 2'b00);
      rd(`PPEF_OFF_RAW, 34'h38);
      setp(8'h30);
      wr(`PPEF_OFF_CLR, 32'hff, 2'b00);
      rd(`PPEF_OFF_RAW, 34'h00);
      slow <= 1'b0;
      $display("level test done");
      wr(`PPEF_OFF_SENSE, 32'h00, 2'b00);
      wr(`PPEF_OFF_POL, 32'hff, 2'b00);
      wr(`PPEF_OFF_ENA, 32'h10, 2'b00);
      setp(8'h00);
      trig_n = 0;
      setp(8'h10);
      chk("trigger", 34'h1, trig_n);
      ports({1'b1, 8'h10, 8'h80});
      wr(`PPEF_OFF_ENA, 32'h00, 2'b00);
      setp(8'h00);
      setp(8'h10);
      chk("trigger", 34'h1, trig_n);
      $display("trigger test done");
      wr(`PPEF_OFF_FUNC, 32'h00, 2'b00);
      ports({1'b0, 8'h00, 8'h00});
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      ports({1'b0, 8'h00, 8'h80});
      rd(`PPEF_OFF_ENA, 34'h0);
      wr(`PPEF_OFF_FUNC, 32'h80, 2'b00);
      rd(`PPEF_OFF_FUNC, 34'h80);
      $display("function test done");
      final_report;
   end
   initial
   begin
      #100us;
      bad_count++;
      final_report;
   end
endmodule // ppef_port_events_tb
